// *** core/fsc_flags.sv ***
// fpu status and control flag logic between integer unit and fpu
`timescale 1ns/1ps
module fsc_flags
  import fsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        scr_wr,
  input  wire logic [31:0] scr_wdata,
  output logic      [31:0] system_control_reg_zero,
  input  wire logic        task_switched_flag,
  input  wire logic        op_valid,
  input  wire fsc_op_t     op_code,
  input  wire logic        op_done,
  input  wire logic        op_incomplete,
  input  wire logic        stack_fault_evt,
  input  wire logic        stack_overflow,
  input  wire logic        fp_exc_unmasked,
  input  wire logic        err_ack,
  input  wire logic        sw_wr,
  input  wire logic [15:0] sw_wdata,
  output logic      [15:0] status_word,
  input  wire logic        cw_wr,
  input  wire logic [15:0] cw_wdata,
  output logic      [15:0] control_word,
  output logic             affine_closure,
  output logic             trap_valid,
  output logic      [7:0]  trap_vector,
  output logic             ext_error
);
  logic [31:0] next_scr;
  logic [15:0] next_cw;
  logic [15:0] set_mask;
  logic [15:0] clr_mask;
  logic        clr_all;
  logic        wait_type;
  logic        wait_trap;
  fsc_err_t    err_state;
  fsc_err_t    next_err_state;
  logic        next_trap_valid;
  logic [7:0]  next_trap_vector;

  function automatic logic [15:0] bit16(input int pos);
    bit16 = 16'h0001 << pos[3:0];
  endfunction

  // control register: every written bit lands except the fixed type flag
  always_comb begin
    next_scr = system_control_reg_zero;
    if (scr_wr) begin
      next_scr = scr_wdata;
    end
    next_scr[SCR_COPROC_TYPE_BIT] = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      system_control_reg_zero <= SCR_RESET;
    end else begin
      system_control_reg_zero <= next_scr;
    end
  end

  // control word keeps the infinity bit for software only
  always_comb begin
    next_cw = control_word;
    if (cw_wr) begin
      next_cw = cw_wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      control_word <= CW_RESET;
    end else begin
      control_word <= next_cw;
    end
  end

  // always affine regardless of bit 12
  assign affine_closure = 1'b1;

  // status word event masks
  always_comb begin
    set_mask = 16'h0000;
    clr_mask = 16'h0000;
    clr_all  = op_valid && (op_code == FSC_OP_INIT);
    if (op_done && op_incomplete &&
        (op_code == FSC_OP_PREM || op_code == FSC_OP_PREM1)) begin
      clr_mask = bit16(SW_CC0_BIT) | bit16(SW_CC1_BIT) | bit16(SW_CC3_BIT);
    end
    if (op_done && op_code == FSC_OP_PTAN) begin
      if (op_incomplete) begin
        set_mask = set_mask | bit16(SW_CC2_BIT);
      end else begin
        clr_mask = clr_mask | bit16(SW_CC2_BIT);
      end
    end
    if (stack_fault_evt) begin
      set_mask = set_mask | bit16(SW_INVALID_OP_BIT) | bit16(SW_STACK_FAULT_BIT);
      if (stack_overflow) begin
        set_mask = set_mask | bit16(SW_CC1_BIT);
        clr_mask = clr_mask & ~bit16(SW_CC1_BIT);
      end else begin
        clr_mask = clr_mask | bit16(SW_CC1_BIT);
        set_mask = set_mask & ~bit16(SW_CC1_BIT);
      end
    end
  end

  // codes sit at fixed status bits
  fsc_sw_reg u_sw (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .clr_all  (clr_all),
    .load_en  (sw_wr),
    .load_val (sw_wdata),
    .set_mask (set_mask),
    .clr_mask (clr_mask),
    .sw       (status_word)
  );

  assign wait_type = op_valid && (op_code == FSC_OP_WAIT || op_code == FSC_OP_INIT ||
                     op_code == FSC_OP_PREM || op_code == FSC_OP_PREM1 ||
                     op_code == FSC_OP_PTAN || op_code == FSC_OP_OTHER);
  assign wait_trap = wait_type && task_switched_flag &&
                     system_control_reg_zero[SCR_WAIT_MON_BIT];

  // error reporting path; external request holds until acknowledged in a cycle with no new exception
  always_comb begin
    next_err_state   = err_state;
    next_trap_valid  = 1'b0;
    next_trap_vector = 8'h00;
    // wait trap in every state, even with an external request pending
    if (wait_trap) begin
      next_trap_valid  = 1'b1;
      next_trap_vector = VEC_DEV_NOT_AVAIL;
    end
    case (err_state)
      FSC_IDLE, FSC_INT: begin
        next_err_state = FSC_IDLE;
        // a trapped instruction drops an exception of the same cycle
        if (!wait_trap && fp_exc_unmasked) begin
          if (system_control_reg_zero[SCR_NATIVE_ERR_BIT]) begin
            next_err_state   = FSC_INT;
            next_trap_valid  = 1'b1;
            next_trap_vector = VEC_FP_ERROR;
          end else begin
            next_err_state = FSC_EXT;
          end
        end
      end
      FSC_EXT: begin
        // a new exception in the ack cycle keeps the request
        if (err_ack && !fp_exc_unmasked) begin
          next_err_state = FSC_IDLE;
        end
      end
      default: begin
        next_err_state = FSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      err_state   <= FSC_IDLE;
      trap_valid  <= 1'b0;
      trap_vector <= 8'h00;
    end else begin
      err_state   <= next_err_state;
      trap_valid  <= next_trap_valid;
      trap_vector <= next_trap_vector;
    end
  end

  assign ext_error = (err_state == FSC_EXT);

  type_flag_fixed_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    system_control_reg_zero[SCR_COPROC_TYPE_BIT] == 1'b1)
    else $error("type flag not one");

  // native path gives vector 16 next cycle
  native_vector_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (err_state != FSC_EXT && fp_exc_unmasked && !wait_trap &&
     system_control_reg_zero[SCR_NATIVE_ERR_BIT])
    |=> trap_valid && trap_vector == VEC_FP_ERROR && !ext_error)
    else $error("native error not on vector 16");

  native_write_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    scr_wr |=> system_control_reg_zero[SCR_NATIVE_ERR_BIT] ==
               $past(scr_wdata[SCR_NATIVE_ERR_BIT]))
    else $error("native flag write lost");

  native_reset_a: assert property (@(posedge ref_clk)
    $rose(rstn) |-> !system_control_reg_zero[SCR_NATIVE_ERR_BIT])
    else $error("native flag set after reset");

  sequence wait_trap_s;
    wait_type && task_switched_flag && system_control_reg_zero[SCR_WAIT_MON_BIT];
  endsequence

  wait_trap_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    wait_trap_s |=> trap_valid && trap_vector == VEC_DEV_NOT_AVAIL)
    else $error("wait trap missing");

  trap_cause_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !wait_trap && !(fp_exc_unmasked && system_control_reg_zero[SCR_NATIVE_ERR_BIT])
    |=> !trap_valid)
    else $error("trap without cause");

  init_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (op_valid && op_code == FSC_OP_INIT && !stack_fault_evt)
    |=> status_word[SW_CC3_BIT] == 1'b0 && status_word[SW_CC2_BIT:SW_CC0_BIT] == 3'b000)
    else $error("codes not cleared by initialise");

  cc_reset_a: assert property (@(posedge ref_clk)
    $rose(rstn) |-> status_word[SW_CC3_BIT] == 1'b0 &&
                    status_word[SW_CC2_BIT:SW_CC0_BIT] == 3'b000)
    else $error("codes not clear after reset");

  prem_clear_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (op_done && op_incomplete && !stack_fault_evt &&
     (op_code == FSC_OP_PREM || op_code == FSC_OP_PREM1))
    |=> !status_word[SW_CC0_BIT] && !status_word[SW_CC1_BIT] && !status_word[SW_CC3_BIT])
    else $error("remainder codes not cleared");

  // tangent incomplete shows in code two
  tan_incomplete_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (op_done && op_code == FSC_OP_PTAN) |=> status_word[SW_CC2_BIT] == $past(op_incomplete))
    else $error("code two wrong after tangent");

  sequence stack_fault_s;
    stack_fault_evt ##1 (status_word[SW_INVALID_OP_BIT] && status_word[SW_STACK_FAULT_BIT]);
  endsequence

  stack_fault_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    stack_fault_evt |-> stack_fault_s)
    else $error("stack fault flags not set");

  fault_dir_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    stack_fault_evt |=> status_word[SW_CC1_BIT] == $past(stack_overflow))
    else $error("code one wrong on stack fault");

  sequence ext_cause_s;
    err_state != FSC_EXT && fp_exc_unmasked && !wait_trap &&
    !system_control_reg_zero[SCR_NATIVE_ERR_BIT];
  endsequence

  // exception with native flag clear raises the output
  ext_raise_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    ext_cause_s |=> ext_error && !trap_valid)
    else $error("external error not raised");

  ext_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ext_error && !err_ack) |=> ext_error)
    else $error("external error dropped early");

  // ack with no new exception ends the request
  ext_release_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    (ext_error && err_ack && !fp_exc_unmasked) |=> !ext_error)
    else $error("external error not released");

  affine_only_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    cw_wr |=> affine_closure && control_word[CW_INF_CTRL_BIT] == $past(cw_wdata[CW_INF_CTRL_BIT]))
    else $error("infinity bit handling wrong");

  // control word only changes on a write
  cw_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    !cw_wr |=> $stable(control_word))
    else $error("control word changed without write");
endmodule

// *** core/fsc_pkg.sv ***
// constants for the fpu status and control flag block
package fsc_pkg;
  // system control register zero fields
  localparam int SCR_WAIT_MON_BIT   = 1;
  localparam int SCR_COPROC_TYPE_BIT = 4;
  localparam int SCR_NATIVE_ERR_BIT = 5;
  localparam logic [31:0] SCR_RESET = 32'h0000_0010;
  // status word fields
  localparam int SW_INVALID_OP_BIT  = 0;
  localparam int SW_STACK_FAULT_BIT = 6;
  localparam int SW_CC0_BIT         = 8;
  localparam int SW_CC1_BIT         = 9;
  localparam int SW_CC2_BIT         = 10;
  localparam int SW_CC3_BIT         = 14;
  localparam logic [15:0] SW_RESET  = 16'h0000;
  // control word fields
  localparam int CW_INF_CTRL_BIT    = 12;
  localparam logic [15:0] CW_RESET  = 16'h037f;
  // exception vectors
  localparam logic [7:0] VEC_DEV_NOT_AVAIL = 8'h07;
  localparam logic [7:0] VEC_FP_ERROR      = 8'h10;
  // instruction codes presented by the integer unit
  typedef enum logic [3:0] {
    FSC_OP_NONE  = 4'h0,
    FSC_OP_INIT  = 4'h1,
    FSC_OP_PREM  = 4'h2,
    FSC_OP_PREM1 = 4'h3,
    FSC_OP_PTAN  = 4'h4,
    FSC_OP_WAIT  = 4'h5,
    FSC_OP_OTHER = 4'h6
  } fsc_op_t;
  // exception report state
  typedef enum logic [2:0] {
    FSC_IDLE = 3'b001,
    FSC_INT  = 3'b010,
    FSC_EXT  = 3'b100
  } fsc_err_t;
endpackage

// *** core/fsc_sw_reg.sv ***
// status word register with priority of event, clear and load
`timescale 1ns/1ps
module fsc_sw_reg
  import fsc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        clr_all,
  input  wire logic        load_en,
  input  wire logic [15:0] load_val,
  input  wire logic [15:0] set_mask,
  input  wire logic [15:0] clr_mask,
  output logic      [15:0] sw
);
  logic [15:0] next_sw;

  always_comb begin
    next_sw = sw;
    if (clr_all) begin
      next_sw = SW_RESET;
    end else if (load_en) begin
      next_sw = load_val;
    end
    // hardware events win over any load in the same cycle
    next_sw = (next_sw & ~clr_mask) | set_mask;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sw <= SW_RESET;
    end else begin
      sw <= next_sw;
    end
  end
endmodule

// *** verification/fsc_flags_tb.sv ***
// self-checking bench for the fpu status and control flag block
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t ns: got %h, expected %h", $time, (a), (b)); end end
module fsc_flags_tb;
  import fsc_pkg::*;
  typedef struct packed {logic mp; logic ts; fsc_op_t op; logic trap;} fsc_row_t;
  logic        ref_clk = 1'b0, rstn = 1'b0, tsf = 1'b0;
  logic        sw_wr = 1'b0, cw_wr = 1'b0, err_ack = 1'b0;
  logic [15:0] sw_wdata = '0, cw_wdata = '0, sw, cw;
  logic [31:0] scr, scr_wdata;
  logic [7:0]  tvec;
  logic        aff, tv, ext, scr_wr, op_valid, op_done, op_inc, sfe, sov, fpe;
  fsc_op_t     op_code;
  int          errors = 0, checks_done = 0, k;
  fsc_row_t    rows [5] = '{'{1'b1, 1'b1, FSC_OP_WAIT, 1'b1}, '{1'b1, 1'b1, FSC_OP_OTHER, 1'b1},
                            '{1'b1, 1'b1, FSC_OP_PTAN, 1'b1}, '{1'b0, 1'b1, FSC_OP_WAIT, 1'b0},
                            '{1'b1, 1'b0, FSC_OP_WAIT, 1'b0}};
  fsc_iu_model u_iu (.ref_clk(ref_clk), .scr_wr(scr_wr), .scr_wdata(scr_wdata),
    .op_valid(op_valid), .op_code(op_code), .op_done(op_done), .op_incomplete(op_inc),
    .stack_fault_evt(sfe), .stack_overflow(sov), .fp_exc_unmasked(fpe));
  fsc_flags u_dut (.ref_clk(ref_clk), .rstn(rstn), .scr_wr(scr_wr), .scr_wdata(scr_wdata),
    .system_control_reg_zero(scr), .task_switched_flag(tsf), .op_valid(op_valid),
    .op_code(op_code), .op_done(op_done), .op_incomplete(op_inc), .stack_fault_evt(sfe),
    .stack_overflow(sov), .fp_exc_unmasked(fpe), .err_ack(err_ack), .sw_wr(sw_wr),
    .sw_wdata(sw_wdata), .status_word(sw), .cw_wr(cw_wr), .cw_wdata(cw_wdata),
    .control_word(cw), .affine_closure(aff), .trap_valid(tv), .trap_vector(tvec),
    .ext_error(ext));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic tick();
    @(posedge ref_clk);
    #10;
  endtask
  task automatic load_sw(input logic [15:0] v);
    sw_wdata = v;
    sw_wr = 1'b1;
    tick();
    sw_wr = 1'b0;
  endtask
  task automatic finish_test();
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #10;
    rstn = 1'b1;
    `CHK(scr, SCR_RESET)
    `CHK(sw, SW_RESET)
    `CHK(cw, CW_RESET)
    foreach (rows[i]) begin
      u_iu.ctrl(rows[i].mp, 1'b0);
      `CHK(scr[4], 1'b1)
      tsf = rows[i].ts;
      u_iu.issue(rows[i].op);
      `CHK(tv, rows[i].trap)
      `CHK(tvec, rows[i].trap ? VEC_DEV_NOT_AVAIL : 8'h00)
      tick();
      `CHK(tv, 1'b0)
    end
    tsf = 1'b0;
    // initialise clears codes over a full load
    load_sw(16'hffff);
    u_iu.issue(FSC_OP_INIT);
    `CHK({sw[14], sw[10:8]}, 4'h0)
    // both remainder forms, each after its own reload
    for (k = 0; k < 2; k++) begin
      load_sw(16'h4700);
      u_iu.finish(fsc_op_t'(k ? FSC_OP_PREM1 : FSC_OP_PREM), 1'b1);
      `CHK({sw[14], sw[10:8]}, 4'b0100)
    end
    load_sw(16'h0000);
    u_iu.finish(FSC_OP_PTAN, 1'b1);
    `CHK(sw[10], 1'b1)
    tick();
    u_iu.finish(FSC_OP_PTAN, 1'b0);
    `CHK(sw[10], 1'b0)
    load_sw(16'h0000);
    u_iu.fault(1'b1);
    `CHK({sw[9], sw[6], sw[0]}, 3'b111)
    load_sw(16'h0200);
    u_iu.fault(1'b0);
    `CHK({sw[9], sw[6], sw[0]}, 3'b011)
    // infinity bit stored, closure stays affine
    for (k = 0; k < 2; k++) begin
      cw_wdata = k ? 16'h0000 : 16'h1000;
      cw_wr = 1'b1;
      tick();
      cw_wr = 1'b0;
      `CHK(cw[12], ~k[0])
      `CHK(aff, 1'b1)
      tick();
    end
    u_iu.ctrl(1'b1, 1'b0);
    u_iu.exc();
    `CHK(ext, 1'b1)
    `CHK(tv, 1'b0)
    // wait trap still taken while the external request is pending
    tsf = 1'b1;
    u_iu.issue(FSC_OP_WAIT);
    `CHK(tvec, VEC_DEV_NOT_AVAIL)
    `CHK(ext, 1'b1)
    tsf = 1'b0;
    err_ack = 1'b1;
    k = 0;
    do begin
      tick();
      k++;
    end while (ext !== 1'b0 && k < 4);
    err_ack = 1'b0;
    `CHK(ext, 1'b0)
    `CHK(k, 1)
    if (k >= 4) begin
      errors++;
      finish_test();
    end
    u_iu.ctrl(1'b1, 1'b1);
    u_iu.exc();
    `CHK(tv, 1'b1)
    `CHK(tvec, VEC_FP_ERROR)
    `CHK(ext, 1'b0)
    // mid-run reset drops native flag and codes
    load_sw(16'h4700);
    rstn = 1'b0;
    tick();
    rstn = 1'b1;
    `CHK(scr[5:4], 2'b01)
    `CHK({sw[14], sw[10:8]}, 4'h0)
    finish_test();
  end
endmodule

// *** verification/fsc_iu_model.sv ***
// integer execution unit model that feeds fp work and control writes to the flag block
`timescale 1ns/1ps
module fsc_iu_model
  import fsc_pkg::*;
(
  input  wire logic        ref_clk,
  output logic             scr_wr,
  output logic      [31:0] scr_wdata,
  output logic             op_valid,
  output fsc_op_t          op_code,
  output logic             op_done,
  output logic             op_incomplete,
  output logic             stack_fault_evt,
  output logic             stack_overflow,
  output logic             fp_exc_unmasked
);
  initial begin
    {scr_wr, op_valid, op_done, op_incomplete} = '0;
    {stack_fault_evt, stack_overflow, fp_exc_unmasked} = '0;
    scr_wdata = '0;
    op_code = FSC_OP_NONE;
  end
  // one strobe cycle; each task drops only what it raised, so calls can follow each other
  task automatic step();
    @(posedge ref_clk);
    #10;
  endtask
  task automatic ctrl(input logic mp, input logic ne);
    scr_wr = 1'b1;
    // type bit sent clear on purpose: the block must keep it set
    scr_wdata = {26'h0, ne, 1'b0, 2'b00, mp, 1'b0};
    step();
    scr_wr = 1'b0;
    // scrambled so a stale word never looks like a fresh write
    scr_wdata = ~scr_wdata;
  endtask
  task automatic issue(input fsc_op_t op);
    op_valid = 1'b1;
    op_code = op;
    step();
    op_valid = 1'b0;
    op_code = FSC_OP_NONE;
  endtask
  task automatic finish(input fsc_op_t op, input logic inc);
    op_done = 1'b1;
    op_code = op;
    op_incomplete = inc;
    step();
    op_done = 1'b0;
    op_incomplete = 1'b0;
    op_code = FSC_OP_NONE;
  endtask
  task automatic fault(input logic ovf);
    stack_fault_evt = 1'b1;
    stack_overflow = ovf;
    step();
    stack_fault_evt = 1'b0;
    stack_overflow = ~stack_overflow;
  endtask
  task automatic exc();
    fp_exc_unmasked = 1'b1;
    step();
    fp_exc_unmasked = 1'b0;
  endtask
endmodule
